// [rtl/lcdrc_core.v]
`timescale 1ns/1ps
`include "lcdrc_defs.vh"
// Function
// [RULE1] Reset clears controls, keeps display memory
// [RULE2] Reset selects 1/16 duty, 1/5 bias
// [RULE3] Reset stops oscillator, display off
// [RULE4] Reset drives all outputs to ground
// [RULE5] Reset disables regulator, pump, bias circuit
// [RULE6] Reset makes general outputs binary
// [RULE7] Reset selects 200 Hz frame, blink off
// [RULE8] Host waits 1 ms before transfers; the bench waits PWR_WAIT = 250 cycles, 1 us
// [RULE9] Host issues software reset if unsure
// [RULE10] Oscillator clocks logic, frame and PWM
// [RULE11] Pump ratio selectable two to five
// [RULE12] Contrast code only with resistor divider
// [RULE13] Pump ratio follows bias setting
// [RULE14] Divider offers three resistors, external supply
// [RULE15] Segment from common timing and latch
// [RULE16] PWM 64 levels per frame, synchronised; the code steps phase_q once per system tick, free of the frame
// [RULE17] Memory one is on, zero off
// [RULE18] Two pages only at 1/8 or less
// [RULE19] Maximum address depends on duty
// [RULE20] Active commons equal duty denominator
// [RULE21] High duties use byte pairs per segment
// [RULE22] Low duties one byte per page
// [RULE23] Writes beyond maximum address are ignored
module lcdrc_core #(
    parameter NSEG    = 60,
    parameter NCOM    = 16,
    parameter NGPO    = 4,
    parameter SYS_DIV = 16'h03F8
) (
    input  wire              ref_clk,
    input  wire              rst_n,
    input  wire              clk_en,
    input  wire              soft_reset,
    input  wire              wr_en,
    input  wire              wr_page,
    input  wire [7:0]        wr_addr,
    input  wire [7:0]        wr_data,
    input  wire              rd_page,
    input  wire [7:0]        rd_addr,
    output reg  [7:0]        rd_data_q,
    input  wire              cfg_we,
    input  wire [3:0]        duty_in,
    input  wire [2:0]        bias_in,
    input  wire              osc_on_in,
    input  wire              disp_on_in,
    input  wire [3:0]        frame_in,
    input  wire [1:0]        blink_in,
    input  wire              page_select_in,
    input  wire              reg_en_in,
    input  wire              pump_en_in,
    input  wire [2:0]        pump_ratio_in,
    input  wire [1:0]        bias_circuit_in,
    input  wire [3:0]        contrast_code_in,
    input  wire [1:0]        res_sel_in,
    input  wire [NGPO-1:0]   gpo_bin_in,
    input  wire [NGPO-1:0]   pwm_mode_in,
    input  wire [NGPO-1:0]   pwm_en_in,
    input  wire [6*NGPO-1:0] pwm_level_in,
    output wire [3:0]        duty,
    output wire [2:0]        bias,
    output wire              osc_on,
    output wire              disp_on,
    output wire [3:0]        frame_sel,
    output wire [1:0]        blink_sel,
    output wire              regulator_en,
    output reg  [2:0]        pump_ratio_q,
    output reg               pump_on_q,
    output reg               bias_on_q,
    output reg               divider_mode_q,
    output reg  [3:0]        contrast_code_q,
    output reg  [1:0]        res_sel_q,
    output reg  [7:0]        max_addr_q,
    output reg  [NCOM-1:0]   common_output,
    output reg  [NCOM-1:0]   common_active_q,
    output reg  [NSEG+NCOM-1:0] segment_output,
    output wire [NGPO-1:0]   general_output
);
    localparam NTOT = NSEG + NCOM;
    localparam [1:0] BC_OFF  = 2'h0;
    localparam [1:0] BC_PUMP = 2'h1;
    localparam [1:0] BC_RDIV = 2'h3;

    reg [3:0]  duty_q;
    reg [2:0]  bias_q;
    reg        osc_q, disp_q, page_q, reg_q, pump_q;
    reg [3:0]  frame_q;
    reg [1:0]  blink_q, bc_q;
    reg [2:0]  ratio_req_q;
    reg [3:0]  ca_q;
    reg [1:0]  rs_q;
    reg [NGPO-1:0]   bin_q, mode_q, pen_q;
    reg [6*NGPO-1:0] lvl_q;
    reg [7:0]  ram_q [0:2*`LCDRC_RAM_WORDS-1];
    reg [15:0] div_q;
    reg        tick_q;
    reg [5:0]  phase_q;
    reg [3:0]  com_q;
    integer    k;

    wire ctl_rst = !rst_n || soft_reset;
    wire low_duty = (duty_q <= `LCDRC_DUTY_8);

    // Maximum valid address for a duty
    function [7:0] max_for;
        input [3:0] d;
        begin
            if (d >= `LCDRC_DUTY_9)
                max_for = `LCDRC_MAX_D16 + {3'h0, ~d, 1'b0}; // [RULE19]
            else if (d <= 4'h3)
                max_for = `LCDRC_MAX_D4;
            else
                max_for = `LCDRC_MAX_D8 + {4'h0, 4'h7 - d}; // [RULE19]
        end
    endfunction

    // Flat memory index: page 1 sits directly above page 0
    function [8:0] ram_idx;
        input       pg;
        input [7:0] ad;
        begin
            ram_idx = {1'b0, ad} + (pg ? `LCDRC_RAM_WORDS : 9'h000); // [RULE18]
        end
    endfunction

    // Control fields
    always @(posedge ref_clk) begin
        if (ctl_rst) begin
            duty_q  <= `LCDRC_DUTY_RST; // [RULE1] [RULE2]
            bias_q  <= `LCDRC_BIAS_RST; // [RULE2]
            osc_q   <= 1'b0; // [RULE3]
            disp_q  <= 1'b0; // [RULE3]
            frame_q <= `LCDRC_FRAME_RST; // [RULE7]
            blink_q <= `LCDRC_BLINK_RST; // [RULE7]
            page_q  <= 1'b0;
            reg_q   <= 1'b0; // [RULE5]
            pump_q  <= 1'b0; // [RULE5]
            ratio_req_q <= 3'h0;
            bc_q    <= BC_OFF; // [RULE5]
            ca_q    <= `LCDRC_CTRL_RST;
            rs_q    <= `LCDRC_RES_RST;
            bin_q   <= {NGPO{1'b0}};
            mode_q  <= {NGPO{1'b0}}; // [RULE6]
            pen_q   <= {NGPO{1'b0}};
            lvl_q   <= {6*NGPO{1'b0}};
        end else if (clk_en && cfg_we) begin
            duty_q  <= duty_in;
            bias_q  <= bias_in;
            osc_q   <= osc_on_in;
            disp_q  <= disp_on_in;
            frame_q <= frame_in;
            blink_q <= blink_in;
            page_q  <= page_select_in;
            reg_q   <= reg_en_in;
            pump_q  <= pump_en_in;
            ratio_req_q <= pump_ratio_in;
            bc_q    <= bias_circuit_in;
            ca_q    <= contrast_code_in;
            if (res_sel_in != 2'h3)
                rs_q <= res_sel_in; // [RULE14]
            bin_q   <= gpo_bin_in;
            mode_q  <= pwm_mode_in;
            pen_q   <= pwm_en_in;
            lvl_q   <= pwm_level_in;
        end
    end

    // Bias and pump derived state
    always @(posedge ref_clk) begin
        if (ctl_rst) begin
            pump_ratio_q    <= 3'h0;
            pump_on_q       <= 1'b0;
            bias_on_q       <= 1'b0;
            divider_mode_q  <= 1'b0;
            contrast_code_q <= 4'h0;
            res_sel_q       <= `LCDRC_RES_RST;
            max_addr_q      <= `LCDRC_MAX_D16;
        end else if (clk_en) begin
            if (bc_q == BC_PUMP)
                pump_ratio_q <= (bias_q == `LCDRC_BIAS_STATIC) ? 3'h1 :
                                (bias_q + 3'h1); // [RULE13]
            else
                pump_ratio_q <= (ratio_req_q >= 3'h2 && ratio_req_q <= 3'h5) ?
                                ratio_req_q : 3'h2; // [RULE11]
            pump_on_q       <= pump_q && (bc_q != BC_RDIV); // [RULE14]
            bias_on_q       <= (bc_q != BC_OFF);
            divider_mode_q  <= (bc_q == BC_RDIV); // [RULE14]
            contrast_code_q <= (bc_q == BC_RDIV) ? ca_q : 4'h0; // [RULE12]
            res_sel_q       <= rs_q; // [RULE14]
            max_addr_q      <= max_for(duty_q); // [RULE19]
        end
    end

    // Display memory: untouched by reset, bounded writes
    always @(posedge ref_clk) begin
        if (clk_en && wr_en && wr_addr <= max_for(duty_q)) begin // [RULE23] [RULE1]
            if (!wr_page || low_duty) // [RULE18]
                ram_q[ram_idx(wr_page && low_duty, wr_addr)] <= wr_data;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n)
            rd_data_q <= 8'h00;
        else if (clk_en)
            rd_data_q <= (rd_addr < `LCDRC_RAM_WORDS) ?
                         ram_q[ram_idx(rd_page && low_duty, rd_addr)] : 8'h00;
    end

    // System clock tick from the oscillator divider
    always @(posedge ref_clk) begin
        if (ctl_rst || !osc_q) begin
            div_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            tick_q <= (div_q == SYS_DIV - 16'h0001); // [RULE10]
            div_q  <= (div_q == SYS_DIV - 16'h0001) ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // Common scan and PWM phase both run on the system tick
    always @(posedge ref_clk) begin
        if (ctl_rst) begin
            com_q   <= 4'h0;
            phase_q <= 6'h00;
        end else if (clk_en && tick_q) begin
            com_q   <= (com_q >= duty_q) ? 4'h0 : com_q + 4'h1; // [RULE10]
            phase_q <= phase_q + 6'h01; // [RULE16]
        end
    end

    // Panel drive
    always @(posedge ref_clk) begin
        if (ctl_rst) begin
            common_output   <= {NCOM{1'b0}}; // [RULE4]
            common_active_q <= {NCOM{1'b0}};
            segment_output  <= {NTOT{1'b0}}; // [RULE4]
        end else if (clk_en) begin
            for (k = 0; k < NCOM; k = k + 1) begin
                common_active_q[k] <= (k <= duty_q); // [RULE20]
                common_output[k]   <= disp_q && (k == com_q) && (k <= duty_q);
            end
            for (k = 0; k < NTOT; k = k + 1) begin
                if (!disp_q)
                    segment_output[k] <= 1'b0;
                else if (k < NSEG + NCOM - 1 - duty_q) begin
                    if (duty_q >= `LCDRC_DUTY_9)
                        segment_output[k] <= ram_q[2*k + com_q[3]][com_q[2:0]]; // [RULE21]
                    else
                        segment_output[k] <= ram_q[ram_idx(page_q, k[7:0])][com_q[2:0]]; // [RULE22]
                end else
                    segment_output[k] <= 1'b0; // [RULE15] [RULE17]
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NGPO; g = g + 1) begin : gen_gpo
            lcdrc_pwm #(.W(6)) u_pwm (
                .ref_clk  (ref_clk),
                .rst_n    (!ctl_rst),
                .clk_en   (clk_en),
                .tick     (tick_q),
                .phase    (phase_q),
                .pwm_mode (mode_q[g]),
                .pwm_en   (pen_q[g]),
                .bin_val  (bin_q[g]),
                .level    (lvl_q[6*g +: 6]),
                .gpo_q    (general_output[g])
            );
        end
    endgenerate

    assign duty         = duty_q;
    assign bias         = bias_q;
    assign osc_on       = osc_q;
    assign disp_on      = disp_q;
    assign frame_sel    = frame_q;
    assign blink_sel    = blink_q;
    assign regulator_en = reg_q;
endmodule // lcdrc_core

// [rtl/lcdrc_defs.vh]
`ifndef LCDRC_DEFS_VH
`define LCDRC_DEFS_VH
// Reset values of control fields
`define LCDRC_DUTY_RST      4'hF
`define LCDRC_BIAS_RST      3'h4
`define LCDRC_FRAME_RST     4'hA
`define LCDRC_BLINK_RST     2'h0
`define LCDRC_RES_RST       2'h2
`define LCDRC_CTRL_RST      4'h0
// Duty field codes
`define LCDRC_DUTY_8        4'h7
`define LCDRC_DUTY_9        4'h8
// Maximum address figures
`define LCDRC_MAX_D16       8'h77
`define LCDRC_MAX_D8        8'h43
`define LCDRC_MAX_D4        8'h47
// Bias codes
`define LCDRC_BIAS_STATIC   3'h0
// Resistor divider codes
`define LCDRC_RES_4K        2'h0
`define LCDRC_RES_8K        2'h1
`define LCDRC_RES_16K       2'h2
// Memory size in bytes per page
`define LCDRC_RAM_WORDS     9'h088
// Oscillator divide from ref clock to system tick
`define LCDRC_SYS_DIV       16'h03F8
`endif

// [rtl/lcdrc_pwm.v]
`timescale 1ns/1ps
// One 64-level pulse-width channel with binary fallback
module lcdrc_pwm #(
    parameter W = 6
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire         clk_en,
    input  wire         tick,
    input  wire [W-1:0] phase,
    input  wire         pwm_mode,
    input  wire         pwm_en,
    input  wire         bin_val,
    input  wire [W-1:0] level,
    output reg          gpo_q
);
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            gpo_q <= 1'b0; // [RULE4]
        end else if (clk_en && tick) begin
            if (pwm_mode)
                gpo_q <= pwm_en && (phase <= level); // [RULE16]
            else
                gpo_q <= bin_val; // [RULE6]
        end
    end
endmodule // lcdrc_pwm

// [bench/lcdrc_panel.sv]
`timescale 1ns/1ps
// Panel pixel at first segment and first common
module lcdrc_panel #(
    parameter NCOM = 16
) (
    input wire            ref_clk,
    input wire [NCOM-1:0] common_output,
    input wire            seg0,
    input wire            clr
);
    int on_cnt;
    // Pixel is lit while its common is scanned and its segment is on
    always @(posedge ref_clk) begin
        if (clr)
            on_cnt <= 0;
        else if (common_output[0] === 1'b1 && seg0 === 1'b1)
            on_cnt <= on_cnt + 1;
    end
endmodule // lcdrc_panel

// [bench/lcdrc_core_checker.sv]
`timescale 1ns/1ps
module lcdrc_core_checker #(
    parameter NSEG = 60,
    parameter NCOM = 16,
    parameter NGPO = 4
) (
    input wire                 ref_clk,
    input wire                 rst_n,
    input wire                 clk_en,
    input wire                 soft_reset,
    input wire [3:0]           duty,
    input wire [2:0]           bias,
    input wire                 osc_on,
    input wire                 disp_on,
    input wire [3:0]           frame_sel,
    input wire [1:0]           blink_sel,
    input wire                 regulator_en,
    input wire                 pump_on_q,
    input wire                 bias_on_q,
    input wire [1:0]           res_sel_q,
    input wire [7:0]           max_addr_q,
    input wire [NCOM-1:0]      common_output,
    input wire [NCOM-1:0]      common_active_q,
    input wire [NSEG+NCOM-1:0] segment_output,
    input wire [NGPO-1:0]      general_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic settled_q;
    always @(posedge ref_clk) settled_q <= rst_n && clk_en && !soft_reset;
    function automatic logic [7:0] f_max(input logic [3:0] d);
        if (d[3]) return 8'h77 + {4'h0, ~d[2:0], 1'b0};
        if (d > 4'h2) return 8'h43 + {5'h0, ~d[2:0]};
        return 8'h47;
    endfunction
    property p_rst_mode;
        !$past(rst_n) |-> duty == 4'hF && bias == 3'h4 && !osc_on && !disp_on;
    endproperty
    property p_rst_out;
        !$past(rst_n) |-> frame_sel == 4'hA && blink_sel == 2'h0 && general_output == '0
            && common_output == '0 && segment_output == '0;
    endproperty
    property p_rst_pwr;
        !$past(rst_n) |-> !regulator_en && !pump_on_q && !bias_on_q && max_addr_q == 8'h77;
    endproperty
    property p_soft;
        clk_en && soft_reset |=> duty == 4'hF && !osc_on && !disp_on && !regulator_en;
    endproperty
    property p_max; settled_q && $stable(duty) |-> max_addr_q == f_max(duty); endproperty
    property p_act;
        settled_q && $stable(duty) |-> common_active_q == NCOM'((32'h2 << duty) - 32'h1);
    endproperty
    property p_com;
        settled_q && $stable(common_active_q) |-> (common_output & ~common_active_q) == '0;
    endproperty
    property p_res; res_sel_q != 2'h3; endproperty
    property p_off;
        !disp_on && !$past(disp_on) |-> common_output == '0 && segment_output == '0;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("reset mode wrong");
    a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong");
    a_rst_pwr: assert property (p_rst_pwr) else $error("reset power wrong");
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    a_max: assert property (p_max) else $error("max address wrong");
    a_act: assert property (p_act) else $error("active commons wrong");
    a_com: assert property (p_com) else $error("idle common driven");
    a_res: assert property (p_res) else $error("resistor code wrong");
    a_off: assert property (p_off) else $error("outputs live while off");
    c_low: cover property (duty == 4'h7 && disp_on);
    c_soft: cover property (soft_reset && clk_en);
    c_pwm: cover property (general_output[0]);
endmodule // lcdrc_core_checker
bind lcdrc_core lcdrc_core_checker #(.NSEG(NSEG), .NCOM(NCOM), .NGPO(NGPO)) u_chk (.*);

// [bench/lcdrc_core_bench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module lcdrc_core_bench;
    localparam int PWR_WAIT = 250;
    logic        ref_clk = '0, rst_n = '0, clk_en = 1'h1, soft_reset = '0, cfg_we = '0;
    logic        wr_en = '0, wr_page = '0, rd_page = '0, osc_on_in = '0, disp_on_in = '0;
    logic        page_select_in = '0, reg_en_in = '0, pump_en_in = '0, clr = '0;
    logic [1:0]  blink_in = '0, bias_circuit_in = '0, res_sel_in = '0;
    logic [2:0]  bias_in = '0, pump_ratio_in = '0;
    logic [3:0]  duty_in = 4'hF, frame_in = 4'hA, contrast_code_in = '0;
    logic [3:0]  gpo_bin_in = '0, pwm_mode_in = '0, pwm_en_in = '0;
    logic [7:0]  wr_addr = '0, wr_data = '0, rd_addr = '0, q, a, p;
    logic [23:0] pwm_level_in = '0;
    logic [31:0] seed = 32'h1680, r;
    wire  [7:0]  rd_data_q, max_addr_q;
    wire  [3:0]  duty, frame_sel, contrast_code_q, general_output;
    wire  [2:0]  bias, pump_ratio_q;
    wire  [1:0]  blink_sel, res_sel_q;
    wire         osc_on, disp_on, regulator_en, pump_on_q, bias_on_q, divider_mode_q;
    wire  [15:0] common_output, common_active_q;
    wire  [75:0] segment_output;
    int          error_cnt = 0, num_checks = 0, n0, n1;
    lcdrc_core #(.SYS_DIV(16'h0004)) dut (.*);
    lcdrc_panel #(.NCOM(16)) u_panel (.ref_clk(ref_clk), .common_output(common_output),
        .seg0(segment_output[0]), .clr(clr));
    always #2 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] f_max(input logic [3:0] d);
        if (d[3]) return 8'h77 + {4'h0, ~d[2:0], 1'b0};
        if (d > 4'h2) return 8'h43 + {5'h0, ~d[2:0]};
        return 8'h47;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cfg(input logic [3:0] d, input logic on, input logic pg);
        r = rnd();
        {reg_en_in, pump_en_in, pump_ratio_in, bias_circuit_in} = r[17:11];
        {contrast_code_in, res_sel_in, blink_in, bias_in} = r[10:0];
        duty_in = d;
        {osc_on_in, disp_on_in, page_select_in} = {on, on, pg};
        cfg_we = 1'h1;
        tick(1);
        cfg_we = 1'h0;
        tick(1);
    endtask
    task automatic wr(input logic pg, input logic [7:0] ad, input logic [7:0] dt);
        {wr_en, wr_page, wr_addr, wr_data} = {1'h1, pg, ad, dt};
        tick(1);
        wr_en = 1'h0;
        tick(1);
    endtask
    task automatic rd(input logic pg, input logic [7:0] ad);
        {rd_page, rd_addr} = {pg, ad};
        tick(1);
        q = rd_data_q;
    endtask
    task automatic lit(input logic pg, output int n);
        cfg(4'h7, 1'h1, pg);
        clr = 1'h1;
        tick(1);
        clr = 1'h0;
        tick(2000);
        n = u_panel.on_cnt;
    endtask
    task automatic pwm_hi(input logic [5:0] lv, output int n);
        pwm_level_in = {18'h0, lv};
        cfg(4'hF, 1'h1, 1'h0);
        tick(400);
        n = 0;
        repeat (4096) begin
            tick(1);
            n += general_output[0];
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(2);
        rst_n = 1'h1;
        `CHK({duty, bias, osc_on, disp_on}, 9'h1F0)
        `CHK({frame_sel, blink_sel, general_output}, 10'h280)
        `CHK({regulator_en, pump_on_q, bias_on_q}, 3'h0)
        tick(PWR_WAIT);
        wr(1'h0, 8'h10, 8'h5A);
        rst_n = 1'h0;
        tick(2);
        rst_n = 1'h1;
        rd(1'h0, 8'h10);
        `CHK(q, 8'h5A)
        cfg(4'h7, 1'h1, 1'h0);
        soft_reset = 1'h1;
        tick(1);
        soft_reset = 1'h0;
        rd(1'h0, 8'h10);
        `CHK({q, duty, osc_on}, 13'h0B5E)
        for (int d = 0; d < 16; d++) begin
            a = f_max(d[3:0]);
            r = rnd();
            p = r[7:0];
            cfg(4'h8, 1'h0, 1'h0);
            if (a != 8'h85) wr(1'h0, a + 8'h1, p);
            cfg(d[3:0], 1'h0, 1'h0);
            `CHK(contrast_code_q, bias_circuit_in == 2'h3 ? contrast_code_in : 4'h0)
            `CHK(divider_mode_q, bias_circuit_in == 2'h3)
            if (bias_circuit_in == 2'h1 && bias_in <= 3'h4) begin
                `CHK(pump_ratio_q, (bias_in == 3'h0) ? 3'h1 : bias_in + 3'h1)
            end else if (bias_circuit_in != 2'h1) begin
                `CHK(pump_ratio_q, (pump_ratio_in-3'h2) < 3'h4 ? pump_ratio_in : 3'h2)
            end
            wr(1'h0, a, ~p);
            wr(1'h0, a + 8'h1, p ^ 8'h3C);
            rd(1'h0, a);
            `CHK(q, ~p)
            rd(1'h0, a + 8'h1);
            if (a != 8'h85) `CHK(q, p)
        end
        cfg(4'h7, 1'h0, 1'h0);
        wr(1'h1, 8'h00, 8'hC3);
        wr(1'h0, 8'h00, 8'h00);
        cfg(4'hF, 1'h0, 1'h0);
        wr(1'h1, 8'h00, 8'h99);
        cfg(4'h7, 1'h0, 1'h0);
        rd(1'h1, 8'h00);
        `CHK(q, 8'hC3)
        rd(1'h0, 8'h00);
        `CHK(q, 8'h00)
        lit(1'h0, n0);
        lit(1'h1, n1);
        `CHK(n1 > n0, 1'b1)
        `CHK(n0, 0)
        gpo_bin_in = 4'hA;
        cfg(4'hF, 1'h1, 1'h0);
        tick(8);
        `CHK(general_output, 4'hA)
        {pwm_mode_in, pwm_en_in} = 8'h11;
        pwm_hi(6'h00, n0);
        pwm_hi(6'h3F, n1);
        `CHK(n1, 4096)
        `CHK(n0 > 0 && n0 < n1, 1'b1)
        `CHK(n0, 64)
        close_out();
    end
    initial begin
        #120000;
        error_cnt++;
        close_out();
    end
endmodule // lcdrc_core_bench
